// ### rtl/iskip_params.svh
// Constants for the increment-and-skip execute block.
// Assumes an 8-bit data path and 16-bit program words.
`ifndef ISKIP_PARAMS_SVH
`define ISKIP_PARAMS_SVH

// ****************************************
// Opcode patterns (upper six bits)
// ****************************************
`define ISKIP_OPC_INCSZ     6'h0F
`define ISKIP_OPC_INCSNZ    6'h12
`define ISKIP_OPC_MSB       15
`define ISKIP_OPC_LSB       10
`define ISKIP_DBIT          9
`define ISKIP_ABIT          8

// ****************************************
// Addressing
// ****************************************
`define ISKIP_IDX_LIMIT     8'h5F
`define ISKIP_ACC_SPLIT     8'h60
`define ISKIP_ACC_HI_BANK   4'hF
`define ISKIP_ONE           8'h01
`define ISKIP_ZERO          8'h00

// ****************************************
// Instruction clock
// ****************************************
`define ISKIP_PHASES        4
`define ISKIP_Q_RESET       2'h0

`endif

// ### rtl/iskip_pkg.sv
// Types for the increment-and-skip execute block.
// Assumes nothing beyond the params header.
package iskip_pkg;
    // Four instruction-clock phases
    typedef enum logic [1:0] {ISKIP_Q1, ISKIP_Q2, ISKIP_Q3, ISKIP_Q4} iskip_phase_e;
    // Execution mode of the current instruction cycle
    typedef enum logic [1:0] {ISKIP_EXEC, ISKIP_FLUSH1, ISKIP_FLUSH2} iskip_mode_e;
endpackage

// ### rtl/iskip_qclk.sv
// Four-phase instruction clock generator.
// Assumes one phase per system clock.
`timescale 1ns/1ps
`default_nettype none
`include "iskip_params.svh"

module iskip_qclk
    import iskip_pkg::*;
(
    input  wire logic         clk_i,   // System clock
    input  wire logic         rstn_i,  // Async reset, active low
    output iskip_phase_e      phase_o  // Current phase
);
    // ****************************************
    // Phase counter
    // ****************************************
    iskip_phase_e phase_ff;     // Registered phase
    iskip_phase_e nxt_phase;    // Next phase

    // Next phase wraps after the fourth
    always_comb begin
        unique case (phase_ff)
            ISKIP_Q1: nxt_phase = ISKIP_Q2;
            ISKIP_Q2: nxt_phase = ISKIP_Q3;
            ISKIP_Q3: nxt_phase = ISKIP_Q4;
            ISKIP_Q4: nxt_phase = ISKIP_Q1;
        endcase
    end

    // Register only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_ff <= ISKIP_Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign phase_o = phase_ff;
endmodule // iskip_qclk
`default_nettype wire

// ### rtl/iskip_exec.sv
// Decode/execute for the two increment-and-skip instructions.
// Assumes the fetch pipeline presents the current word in Q1 and the
// prefetched successor with its two-word flag; data memory answers a
// read with rd_data_i within the strobe phase itself.
//
// Behaviour
// - Decode skip-on-zero opcode, d, a, f
// - Decode skip-on-nonzero opcode, d, a, f
// - Read register f, add one
// - d clear to accumulator, set to f
// - Zero result skips on skip-on-zero
// - Nonzero result skips on skip-on-nonzero
// - a clear access bank, set bank pointer
// - Extended set, a clear, f<=5Fh indexed
// - Status flags never written
// - One word; one cycle, two if skip
// - Two-word successor skip takes three cycles
// - Skip cycles do nothing in all phases
`timescale 1ns/1ps
`default_nettype none
`include "iskip_params.svh"

module iskip_exec
    import iskip_pkg::*;
(
    input  wire logic        clk_i,            // System clock
    input  wire logic        rstn_i,           // Async reset, active low
    input  wire logic [15:0] instr_i,          // Current program word
    input  wire logic        next_two_word_i,  // Prefetched word opens a two-word op
    input  wire logic        ext_set_en_i,     // Extended instruction set enabled
    input  wire logic [3:0]  bank_pointer_reg_i, // Bank pointer value
    input  wire logic [11:0] index_base_i,     // Base for indexed literal offset
    input  wire logic [7:0]  rd_data_i,        // Data memory read data
    output logic             decode_hit_o,     // This cycle executes one of the two
    output logic             rd_en_o,          // Data memory read strobe
    output logic [11:0]      addr_o,           // Data memory address
    output logic             wr_en_o,          // Data memory write strobe
    output logic [7:0]       wr_data_o,        // Data memory write data
    output logic             acc_we_o,         // Accumulator write strobe
    output logic [7:0]       acc_data_o,       // Accumulator write data
    output logic             status_we_o,      // Status write strobe, always low
    output logic             flush_o,          // Discard prefetched word
    output logic             nop_cycle_o       // Current cycle is a skip cycle
);
    // ****************************************
    // Instruction clock
    // ****************************************
    iskip_phase_e phase;    // Current phase

    iskip_qclk u_qclk (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .phase_o (phase)
    );

    // ****************************************
    // Decode (combinational view of the word)
    // ****************************************
    logic       is_sz;      // Skip-on-zero opcode
    logic       is_snz;     // Skip-on-nonzero opcode
    logic       idx_mode;   // Indexed literal offset applies
    logic [11:0] eff_addr;  // Resolved data address

    assign is_sz  = (instr_i[`ISKIP_OPC_MSB:`ISKIP_OPC_LSB] == `ISKIP_OPC_INCSZ);
    assign is_snz = (instr_i[`ISKIP_OPC_MSB:`ISKIP_OPC_LSB] == `ISKIP_OPC_INCSNZ);
    // Indexed only when the access bank would be used
    assign idx_mode = ext_set_en_i && !instr_i[`ISKIP_ABIT]
                      && (instr_i[7:0] <= `ISKIP_IDX_LIMIT);

    // Address resolution: bank pointer, access bank halves, or index
    always_comb begin
        if (instr_i[`ISKIP_ABIT]) begin
            eff_addr = {bank_pointer_reg_i, instr_i[7:0]};
        end else if (idx_mode) begin
            eff_addr = index_base_i + {4'h0, instr_i[7:0]};
        end else if (instr_i[7:0] < `ISKIP_ACC_SPLIT) begin
            eff_addr = {4'h0, instr_i[7:0]};
        end else begin
            eff_addr = {`ISKIP_ACC_HI_BANK, instr_i[7:0]};
        end
    end

    // ****************************************
    // Execution state
    // ****************************************
    iskip_mode_e mode_ff;     // Normal or skip cycle
    iskip_mode_e nxt_mode;
    logic        hit_ff;      // Latched decode result
    logic        nxt_hit;
    logic        sz_ff;       // Latched skip sense
    logic        nxt_sz;
    logic        d_ff;        // Latched destination bit
    logic        nxt_d;
    logic [11:0] addr_ff;     // Latched address
    logic [11:0] nxt_addr;
    logic [7:0]  res_ff;      // Incremented value
    logic [7:0]  nxt_res;
    logic        rd_ff;
    logic        nxt_rd;
    logic        wr_ff;
    logic        nxt_wr;
    logic        accwe_ff;
    logic        nxt_accwe;
    logic        flush_ff;
    logic        nxt_flush;
    logic        two_ff;      // Successor is two words
    logic        nxt_two;
    logic        skip_take;   // Skip condition on the result
    logic        nop_ff;      // Mirrors a non-exec mode
    logic        nxt_nop;

    // Skip decision from the computed result
    assign skip_take = sz_ff ? (res_ff == `ISKIP_ZERO) : (res_ff != `ISKIP_ZERO);

    // Next-state computation for all execution state
    always_comb begin
        nxt_mode  = mode_ff;
        nxt_hit   = hit_ff;
        nxt_sz    = sz_ff;
        nxt_d     = d_ff;
        nxt_addr  = addr_ff;
        nxt_res   = res_ff;
        nxt_rd    = 1'b0;
        nxt_wr    = 1'b0;
        nxt_accwe = 1'b0;
        nxt_flush = 1'b0;
        nxt_two   = two_ff;
        unique case (phase)
            ISKIP_Q1: begin
                // Decode only outside skip cycles
                if (mode_ff == ISKIP_EXEC) begin
                    nxt_hit  = is_sz || is_snz;
                    nxt_sz   = is_sz;
                    nxt_d    = instr_i[`ISKIP_DBIT];
                    nxt_addr = eff_addr;
                    nxt_two  = next_two_word_i;
                    nxt_rd   = is_sz || is_snz;
                end else begin
                    nxt_hit  = 1'b0;
                end
            end
            ISKIP_Q2: begin
                // Read data returns now; compute in this phase's register
                if (hit_ff) begin
                    nxt_res = rd_data_i + `ISKIP_ONE;
                end
            end
            ISKIP_Q3: begin
                // Write destination in Q4
                if (hit_ff) begin
                    nxt_wr    = d_ff;
                    nxt_accwe = !d_ff;
                end
            end
            ISKIP_Q4: begin
                // Choose the next cycle kind
                if (hit_ff && skip_take) begin
                    nxt_flush = 1'b1;
                    nxt_mode  = two_ff ? ISKIP_FLUSH2 : ISKIP_FLUSH1;
                end else if (mode_ff == ISKIP_FLUSH2) begin
                    nxt_mode  = ISKIP_FLUSH1;
                end else begin
                    nxt_mode  = ISKIP_EXEC;
                end
            end
        endcase
        // Skip flag follows the mode that the next edge loads
        nxt_nop = (nxt_mode != ISKIP_EXEC);
    end

    // Register only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_ff  <= ISKIP_EXEC;
            hit_ff   <= 1'b0;
            sz_ff    <= 1'b0;
            d_ff     <= 1'b0;
            addr_ff  <= 12'h000;
            res_ff   <= 8'h00;
            rd_ff    <= 1'b0;
            wr_ff    <= 1'b0;
            accwe_ff <= 1'b0;
            flush_ff <= 1'b0;
            two_ff   <= 1'b0;
            nop_ff   <= 1'b0;
        end else begin
            mode_ff  <= nxt_mode;
            hit_ff   <= nxt_hit;
            sz_ff    <= nxt_sz;
            d_ff     <= nxt_d;
            addr_ff  <= nxt_addr;
            res_ff   <= nxt_res;
            rd_ff    <= nxt_rd;
            wr_ff    <= nxt_wr;
            accwe_ff <= nxt_accwe;
            flush_ff <= nxt_flush;
            two_ff   <= nxt_two;
            nop_ff   <= nxt_nop;
        end
    end

    // ****************************************
    // Outputs, all from flip-flops except the status strobe, tied low
    // ****************************************
    assign decode_hit_o = hit_ff;
    assign rd_en_o      = rd_ff;
    assign addr_o       = addr_ff;
    assign wr_en_o      = wr_ff;
    assign wr_data_o    = res_ff;
    assign acc_we_o     = accwe_ff;
    assign acc_data_o   = res_ff;
    assign status_we_o  = 1'b0;    // Flags untouched by these ops
    assign flush_o      = flush_ff;
    assign nop_cycle_o  = nop_ff;

    // ****************************************
    // Checks
    // ****************************************
    property p_no_status;
        @(posedge clk_i) disable iff (!rstn_i) !status_we_o;
    endproperty
    a_no_status: assert property (p_no_status) else $error("status written");

    property p_read_on_hit;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q1 && mode_ff == ISKIP_EXEC && (is_sz || is_snz)) |=> rd_en_o;
    endproperty
    a_read_on_hit: assert property (p_read_on_hit) else $error("no read on decode");

    property p_dest_excl;
        @(posedge clk_i) disable iff (!rstn_i) !(wr_en_o && acc_we_o);
    endproperty
    a_dest_excl: assert property (p_dest_excl) else $error("two destinations");

    property p_wr_d;
        @(posedge clk_i) disable iff (!rstn_i) wr_en_o |-> d_ff && hit_ff;
    endproperty
    a_wr_d: assert property (p_wr_d) else $error("write without d set");

    property p_skip_quiet;
        @(posedge clk_i) disable iff (!rstn_i) nop_cycle_o |-> !rd_en_o && !wr_en_o && !acc_we_o;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("activity in skip cycle");

    sequence s_flush_two;
        flush_o && two_ff;
    endsequence
    property p_three_cycle;
        @(posedge clk_i) disable iff (!rstn_i) s_flush_two |-> nop_cycle_o [*8] ##1 !nop_cycle_o;
    endproperty
    a_three_cycle: assert property (p_three_cycle) else $error("short two-word skip");

    property p_one_skip;
        @(posedge clk_i) disable iff (!rstn_i) (flush_o && !two_ff) |-> nop_cycle_o [*4] ##1 !nop_cycle_o;
    endproperty
    a_one_skip: assert property (p_one_skip) else $error("skip length wrong");

    property p_sz_zero;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q4 && hit_ff && sz_ff && res_ff == 8'h00) |=> flush_o;
    endproperty
    a_sz_zero: assert property (p_sz_zero) else $error("zero skip missed");

    property p_snz_nz;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q4 && hit_ff && !sz_ff) |=> (flush_o == (res_ff != 8'h00));
    endproperty
    a_snz_nz: assert property (p_snz_nz) else $error("nonzero skip wrong");

    property p_wrap;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q2 && hit_ff) |=> res_ff == 8'($past(rd_data_i) + 8'h01);
    endproperty
    a_wrap: assert property (p_wrap) else $error("increment wrong");

    // A kept successor runs straight after, with no dead cycle
    property p_no_skip_exec;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q4 && hit_ff && !skip_take) |=> !flush_o && !nop_cycle_o;
    endproperty
    a_no_skip_exec: assert property (p_no_skip_exec) else $error("dead cycle without skip");

    // Destination strobes only in the last phase
    property p_dest_q4;
        @(posedge clk_i) disable iff (!rstn_i) (wr_en_o || acc_we_o) |-> phase == ISKIP_Q4;
    endproperty
    a_dest_q4: assert property (p_dest_q4) else $error("write outside last phase");

    // Bank pointer forms the upper address bits when a is set
    property p_bank_addr;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q1 && mode_ff == ISKIP_EXEC && (is_sz || is_snz) && instr_i[`ISKIP_ABIT])
            |=> addr_o == {$past(bank_pointer_reg_i), $past(instr_i[7:0])};
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong");

    // Low access-bank offsets become indexed when the extended set is on
    property p_idx_addr;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q1 && mode_ff == ISKIP_EXEC && (is_sz || is_snz) && ext_set_en_i
             && !instr_i[`ISKIP_ABIT] && instr_i[7:0] <= `ISKIP_IDX_LIMIT)
            |=> addr_o == 12'($past(index_base_i) + {4'h0, $past(instr_i[7:0])});
    endproperty
    a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

    // A word seen in a skip cycle must never be decoded or read
    property p_skip_ignore;
        @(posedge clk_i) disable iff (!rstn_i)
            (phase == ISKIP_Q1 && mode_ff != ISKIP_EXEC) |=> !decode_hit_o && !rd_en_o;
    endproperty
    a_skip_ignore: assert property (p_skip_ignore) else $error("decode in skip cycle");
endmodule // iskip_exec
`default_nettype wire

// ### test/iskip_mem_model.sv
// Data memory model on the far side of the increment-and-skip block.
// Assumes reads are taken in the strobe phase and writes land on the edge.
`timescale 1ns/1ps
`default_nettype none

module iskip_mem_model (
    input  wire logic        clk_i,     // System clock
    input  wire logic        rd_en_i,   // Read strobe
    input  wire logic [11:0] addr_i,    // Data address
    input  wire logic        wr_en_i,   // Write strobe
    input  wire logic [7:0]  wr_data_i, // Write data
    output logic      [7:0]  rd_data_o  // Read data
);
    logic [7:0] mem [0:4095];   // Data space, loaded by the bench
    logic [7:0] last = 8'h00;   // Last value shown

    // Valid in the strobe phase only; inverted after so a late sample shows up
    assign rd_data_o = rd_en_i ? mem[addr_i] : ~last;

    // Write port and hold tracking
    always @(posedge clk_i) begin
        if (rd_en_i) begin
            last <= mem[addr_i];
        end
        if (wr_en_i) begin
            mem[addr_i] <= wr_data_i;
        end
    end
endmodule // iskip_mem_model

`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the increment-and-skip execute block.
// Assumes one instruction per four clocks, taken at the first edge after reset.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk_i, rstn_i, next_two_word_i, ext_set_en_i;
    logic [15:0] instr_i;
    logic [3:0]  bank_pointer_reg_i;
    logic [11:0] index_base_i, addr_o;
    logic [7:0]  rd_data_i, wr_data_o, acc_data_o;
    logic        decode_hit_o, rd_en_o, wr_en_o, acc_we_o, status_we_o, flush_o, nop_cycle_o;
    // Per-cycle traces of one instruction window, bit n is cycle n after the take edge
    logic [15:0] rd_t, wr_t, ac_t, fl_t, nop_t, hit_t, st_t;
    logic [3:0]  cyc;
    logic [11:0] ad_s;
    logic [7:0]  wr_v, ac_v;
    logic        start = 1'b0;
    int          err_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    iskip_exec u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr_i),
        .next_two_word_i(next_two_word_i), .ext_set_en_i(ext_set_en_i),
        .bank_pointer_reg_i(bank_pointer_reg_i), .index_base_i(index_base_i),
        .rd_data_i(rd_data_i), .decode_hit_o(decode_hit_o), .rd_en_o(rd_en_o),
        .addr_o(addr_o), .wr_en_o(wr_en_o), .wr_data_o(wr_data_o), .acc_we_o(acc_we_o),
        .acc_data_o(acc_data_o), .status_we_o(status_we_o), .flush_o(flush_o),
        .nop_cycle_o(nop_cycle_o));

    iskip_mem_model u_mem (.clk_i(clk_i), .rd_en_i(rd_en_o), .addr_i(addr_o),
        .wr_en_i(wr_en_o), .wr_data_i(wr_data_o), .rd_data_o(rd_data_i));

    // ****************************************
    // Clock, watchdog and trace capture
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Reads pre-edge values, so no race with the block's own registers
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            wrap_up();
        end
        if (start) begin
            {rd_t, wr_t, ac_t, fl_t, nop_t, hit_t, st_t} <= '0;
            {ad_s, wr_v, ac_v} <= 'x;
            cyc <= 4'h1;
        end else begin
            cyc <= cyc + 4'h1;
            rd_t[cyc] <= rd_en_o;
            wr_t[cyc] <= wr_en_o;
            ac_t[cyc] <= acc_we_o;
            fl_t[cyc] <= flush_o;
            nop_t[cyc] <= nop_cycle_o;
            hit_t[cyc] <= decode_hit_o;
            st_t[cyc] <= status_we_o;
            if (rd_en_o) begin
                ad_s <= addr_o;
            end
            if (wr_en_o) begin
                wr_v <= wr_data_o;
            end
            if (acc_we_o) begin
                ac_v <= acc_data_o;
            end
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One instruction, a filler word after it, then every trace judged
    task automatic do_op(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f,
                         input logic [7:0] v, input logic two, input logic ext,
                         input logic [3:0] bank, input logic [11:0] base);
        logic [7:0]  res;
        logic [11:0] ea;
        logic        hit;
        logic        skp;
        res = v + 8'h01;
        hit = (opc == 6'h0F) || (opc == 6'h12);
        skp = (opc == 6'h0F) ? (res == 8'h00) : ((opc == 6'h12) && (res != 8'h00));
        if (a) begin
            ea = {bank, f};
        end else if (ext && f <= 8'h5F) begin
            ea = base + {4'h0, f};
        end else begin
            ea = {(f < 8'h60) ? 4'h0 : 4'hF, f};
        end
        u_mem.mem[ea] = v;
        start <= 1'b1;
        instr_i <= {opc, d, a, f};
        next_two_word_i <= two;
        ext_set_en_i <= ext;
        bank_pointer_reg_i <= bank;
        index_base_i <= base;
        @(posedge clk_i);
        start <= 1'b0;
        next_two_word_i <= 1'b0;
        // A discarded successor that looks like a hit must stay ignored
        if (skp) begin
            instr_i <= {6'h0F, 2'b11, f};
            repeat (two ? 8 : 4) @(posedge clk_i);
        end
        instr_i <= 16'h0000;
        repeat (7) @(posedge clk_i);
        chk("hit", hit_t, hit ? 16'h001E : 16'h0000);
        chk("read", rd_t, hit ? 16'h0002 : 16'h0000);
        chk("write", wr_t, (hit && d) ? 16'h0008 : 16'h0000);
        chk("acc", ac_t, (hit && !d) ? 16'h0008 : 16'h0000);
        chk("flush", fl_t, skp ? 16'h0010 : 16'h0000);
        chk("nop", nop_t, !skp ? 16'h0000 : (two ? 16'h0FF0 : 16'h00F0));
        chk("status", st_t, 16'h0000);
        if (hit) begin
            chk("addr", {4'h0, ad_s}, {4'h0, ea});
            chk("result", {8'h00, d ? wr_v : ac_v}, {8'h00, res});
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_zero_skip;
        do_op(6'h0F, 1'b1, 1'b1, 8'h20, 8'hFF, 1'b0, 1'b0, 4'h3, 12'h000);
        do_op(6'h0F, 1'b0, 1'b1, 8'h21, 8'h10, 1'b0, 1'b0, 4'h3, 12'h000);
        $display("test zero_skip done");
    endtask

    task automatic t_nonzero_skip;
        do_op(6'h12, 1'b0, 1'b1, 8'h40, 8'h41, 1'b0, 1'b0, 4'hA, 12'h000);
        do_op(6'h12, 1'b1, 1'b1, 8'h41, 8'hFF, 1'b0, 1'b0, 4'hA, 12'h000);
        $display("test nonzero_skip done");
    endtask

    // Access bank split and the indexed boundary at 5Fh/60h
    task automatic t_addr_modes;
        do_op(6'h0F, 1'b1, 1'b0, 8'h30, 8'h05, 1'b0, 1'b0, 4'h7, 12'h000);
        do_op(6'h12, 1'b1, 1'b0, 8'h90, 8'h05, 1'b0, 1'b1, 4'h7, 12'h100);
        do_op(6'h12, 1'b0, 1'b0, 8'h5F, 8'h07, 1'b0, 1'b1, 4'h7, 12'hFFE);
        do_op(6'h12, 1'b1, 1'b0, 8'h60, 8'h07, 1'b0, 1'b1, 4'h7, 12'h200);
        $display("test addr_modes done");
    endtask

    task automatic t_two_word;
        do_op(6'h0F, 1'b1, 1'b1, 8'h50, 8'hFF, 1'b1, 1'b0, 4'h2, 12'h000);
        do_op(6'h12, 1'b1, 1'b1, 8'h51, 8'h00, 1'b1, 1'b0, 4'h2, 12'h000);
        do_op(6'h0F, 1'b1, 1'b1, 8'h52, 8'h01, 1'b1, 1'b0, 4'h2, 12'h000);
        $display("test two_word done");
    endtask

    // Neighbouring opcodes must leave every strobe and flag quiet
    task automatic t_foreign;
        do_op(6'h0A, 1'b1, 1'b1, 8'h20, 8'hFF, 1'b0, 1'b0, 4'h1, 12'h000);
        do_op(6'h13, 1'b1, 1'b1, 8'h20, 8'h3C, 1'b0, 1'b0, 4'h1, 12'h000);
        do_op(6'h0E, 1'b0, 1'b1, 8'h20, 8'h3C, 1'b0, 1'b0, 4'h1, 12'h000);
        $display("test foreign done");
    endtask

    initial begin
        rstn_i = 1'b0;
        instr_i = 16'h0000;
        next_two_word_i = 1'b0;
        ext_set_en_i = 1'b0;
        bank_pointer_reg_i = 4'h0;
        index_base_i = 12'h000;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_zero_skip();
        t_nonzero_skip();
        t_addr_modes();
        t_two_word();
        t_foreign();
        wrap_up();
    end
endmodule // tb

`default_nettype wire
